//--- sar_link_pkg.sv
// shared constants for the converter control link
package sar_link_pkg;
    // ------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------
    localparam int CFG_BITS      = 8;
    localparam int FRAME_BITS    = 16;
    localparam int RESULT_BITS   = 16;
    localparam int MUX_MSB_POS   = 7;
    localparam int MUX_LSB_POS   = 4;
    localparam int NAP_POS       = 1;
    localparam int SLEEP_POS     = 0;
    localparam int ACQ_FALL_NUM  = 6;
    localparam logic [15:0] SIGN_FLIP   = 16'h8000;
    localparam logic [15:0] RESULT_RST  = 16'h0000;
    localparam logic [7:0]  CFG_RST     = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int CONV_TIME_NS   = 4000;
    localparam int CONV_TIME_PS   = CONV_TIME_NS * 1000;
    localparam int CONV_CYCLES    = CONV_TIME_PS / CLK_PERIOD_PS;
    localparam int ACQ_TIME_NS    = 4000;
    localparam int ACQ_CYCLES     = (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CST_HIGH_NS    = 40;
    localparam int CST_CYCLES     = (CST_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RD_SETUP_NS    = 20;
    localparam int RD_CYCLES      = (RD_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SCK_HALF_NS    = 25;
    localparam int SCK_HALF_CYC   = (SCK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        PD_POWER_ON,
        PD_NAP,
        PD_SLEEP
    } pd_mode_type;
endpackage

//--- sar_link_if.sv
// serial link between the converter control and its host
interface sar_link_if;
    logic shift_clk;
    logic read_n;
    logic serial_cfg_in;
    logic convert_start;
    logic serial_result_out;
    logic serial_result_oe;
    logic busy;

    modport device (
        input  shift_clk,
        input  read_n,
        input  serial_cfg_in,
        input  convert_start,
        output serial_result_out,
        output serial_result_oe,
        output busy
    );

    modport host (
        output shift_clk,
        output read_n,
        output serial_cfg_in,
        output convert_start,
        input  serial_result_out,
        input  serial_result_oe,
        input  busy
    );
endinterface

//--- sar_conv_device.sv
// converter control: serial config/result port and approximation sequencer
module sar_conv_device #(
    parameter int RES_BITS = 16
) (
    // system clock (internal oscillator) and reset
    input  wire logic                        CLK_SYS_IN,
    input  wire logic                        RST_N_IN,
    // analog stand-in: signed sample seen by the comparator
    input  wire logic [15:0]                 SAMPLE_IN,
    // decoded configuration and status
    output logic      [3:0]                  MUX_ADDR_OUT,
    output sar_link_pkg::pd_mode_type        PD_MODE_OUT,
    output logic                             ACQUIRE_OUT,
    // link
    sar_link_if.device                       link
);
    import sar_link_pkg::*;

    localparam int STEP_CYCLES = (CONV_CYCLES / RES_BITS > 0) ? CONV_CYCLES / RES_BITS : 1;

    // ------------------------------------------------------------
    // link domain: shift clock, frame cleared while read is high
    // ------------------------------------------------------------
    logic       frame_rst_n;
    logic [3:0] rise_cnt_q;
    logic [4:0] fall_cnt_q;
    logic [7:0] cfg_sh_q;
    logic       cfg_tgl_q;
    logic       acq_tgl_q;
    logic [15:0] result_q;

    // a raised read enable ends the frame even though the clock has stopped
    assign frame_rst_n = RST_N_IN & ~link.read_n;

    always_ff @(posedge link.shift_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rise_cnt_q <= 4'h0;
        end else if (rise_cnt_q != 4'(CFG_BITS)) begin
            rise_cnt_q <= rise_cnt_q + 4'h1;
        end
    end

    // cfg word and toggle survive the frame so the system side can read them
    always_ff @(posedge link.shift_clk or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            cfg_sh_q  <= CFG_RST;
            cfg_tgl_q <= 1'b0;
        end else if (!link.read_n && rise_cnt_q != 4'(CFG_BITS)) begin
            cfg_sh_q <= {cfg_sh_q[6:0], link.serial_cfg_in};
            if (rise_cnt_q == 4'(CFG_BITS - 1)) begin
                cfg_tgl_q <= ~cfg_tgl_q;
            end
        end
    end

    always_ff @(negedge link.shift_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            fall_cnt_q <= 5'h00;
        end else if (fall_cnt_q != 5'(FRAME_BITS)) begin
            fall_cnt_q <= fall_cnt_q + 5'h01;
        end
    end

    always_ff @(negedge link.shift_clk or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            acq_tgl_q <= 1'b0;
        end else if (!link.read_n && fall_cnt_q == 5'(ACQ_FALL_NUM - 1)) begin
            acq_tgl_q <= ~acq_tgl_q;
        end
    end

    // result_q only changes while busy is low, when no frame may run
    always_comb begin
        if (fall_cnt_q < 5'(FRAME_BITS)) begin
            link.serial_result_out = result_q[4'(15 - fall_cnt_q)];
        end else begin
            link.serial_result_out = 1'b0;
        end
    end
    assign link.serial_result_oe = ~link.read_n;

    // ------------------------------------------------------------
    // system domain: synchronisers
    // ------------------------------------------------------------
    logic [2:0] cst_sync_q;
    logic [2:0] cfg_sync_q;
    logic [2:0] acq_sync_q;
    logic       cst_rise;
    logic       cfg_event;
    logic       acq_event;

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            cst_sync_q <= 3'h0;
            cfg_sync_q <= 3'h0;
            acq_sync_q <= 3'h0;
        end else begin
            cst_sync_q <= {cst_sync_q[1:0], link.convert_start};
            cfg_sync_q <= {cfg_sync_q[1:0], cfg_tgl_q};
            acq_sync_q <= {acq_sync_q[1:0], acq_tgl_q};
        end
    end

    assign cst_rise  = cst_sync_q[1] & ~cst_sync_q[2];
    assign cfg_event = cfg_sync_q[1] ^ cfg_sync_q[2];
    assign acq_event = acq_sync_q[1] ^ acq_sync_q[2];

    // ------------------------------------------------------------
    // configuration and acquisition
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            MUX_ADDR_OUT <= 4'h0;
            PD_MODE_OUT  <= PD_POWER_ON;
        end else if (cfg_event) begin
            MUX_ADDR_OUT <= cfg_sh_q[MUX_MSB_POS:MUX_LSB_POS];
            if (cfg_sh_q[SLEEP_POS]) begin
                PD_MODE_OUT <= PD_SLEEP;
            end else if (cfg_sh_q[NAP_POS]) begin
                PD_MODE_OUT <= PD_NAP;
            end else begin
                PD_MODE_OUT <= PD_POWER_ON;
            end
        end
    end

    typedef enum logic {
        ST_IDLE,
        ST_CONVERT
    } conv_state_type;

    conv_state_type state_q;

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ACQUIRE_OUT <= 1'b0;
        end else if (acq_event) begin
            ACQUIRE_OUT <= 1'b1;
        end else if (state_q == ST_IDLE && cst_rise) begin
            ACQUIRE_OUT <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // successive approximation
    // ------------------------------------------------------------
    logic [15:0] held_q;
    logic [15:0] approx_q;
    logic [3:0]  pos_q;
    logic [15:0] step_q;
    logic [15:0] trial;
    logic        last_bit;

    assign trial    = approx_q | (16'h0001 << pos_q);
    assign last_bit = (pos_q == 4'(RESULT_BITS - RES_BITS));

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q  <= ST_IDLE;
            held_q   <= RESULT_RST;
            approx_q <= RESULT_RST;
            pos_q    <= 4'hF;
            step_q   <= 16'h0000;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (cst_rise) begin
                        state_q  <= ST_CONVERT;
                        held_q   <= SAMPLE_IN ^ SIGN_FLIP;
                        approx_q <= RESULT_RST;
                        pos_q    <= 4'hF;
                        step_q   <= 16'h0000;
                    end
                end
                ST_CONVERT: begin
                    // convert start is not looked at here
                    if (step_q == 16'(STEP_CYCLES - 1)) begin
                        step_q <= 16'h0000;
                        if (trial <= held_q) begin
                            approx_q <= trial;
                        end
                        if (last_bit) begin
                            state_q <= ST_IDLE;
                        end else begin
                            pos_q <= pos_q - 4'h1;
                        end
                    end else begin
                        step_q <= step_q + 16'h0001;
                    end
                end
            endcase
        end
    end

    // low bits beyond the resolution stay zero, giving a 16-bit frame
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            result_q <= RESULT_RST;
        end else if (state_q == ST_CONVERT && step_q == 16'(STEP_CYCLES - 1) && last_bit) begin
            if (trial <= held_q) begin
                result_q <= trial ^ SIGN_FLIP;
            end else begin
                result_q <= approx_q ^ SIGN_FLIP;
            end
        end
    end

    assign link.busy = (state_q == ST_IDLE);
endmodule

//--- sar_conv_host.sv
// host side: generates the shift clock and sequences transfers and conversions
module sar_conv_host (
    // system clock and reset
    input  wire logic        CLK_SYS_IN,
    input  wire logic        RST_N_IN,
    // user request
    input  wire logic        START_IN,
    input  wire logic [7:0]  CFG_IN,
    output logic             READY_OUT,
    // previous result
    output logic [15:0]      RESULT_OUT,
    output logic             RESULT_VALID_OUT,
    // link
    sar_link_if.host         link
);
    import sar_link_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_SHIFT,
        ST_ACQ,
        ST_CST,
        ST_WAIT_LOW,
        ST_WAIT_HIGH
    } host_state_type;

    host_state_type state_q;
    logic [15:0]    cnt_q;
    logic [4:0]     bit_q;
    logic [7:0]     cfg_q;
    logic [15:0]    res_sh_q;
    logic           sck_q;
    logic [1:0]     res_sync_q;
    logic [1:0]     busy_sync_q;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            res_sync_q  <= 2'h0;
            busy_sync_q <= 2'h0;
        end else begin
            res_sync_q  <= {res_sync_q[0], link.serial_result_out & link.serial_result_oe};
            busy_sync_q <= {busy_sync_q[0], link.busy};
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q          <= ST_IDLE;
            cnt_q            <= 16'h0000;
            bit_q            <= 5'h00;
            cfg_q            <= CFG_RST;
            res_sh_q         <= RESULT_RST;
            sck_q            <= 1'b0;
            RESULT_OUT       <= RESULT_RST;
            RESULT_VALID_OUT <= 1'b0;
        end else begin
            RESULT_VALID_OUT <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    // a transfer only starts once busy is seen high
                    if (START_IN && busy_sync_q[1]) begin
                        cfg_q   <= CFG_IN;
                        cnt_q   <= 16'h0000;
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cnt_q == 16'(RD_CYCLES - 1)) begin
                        cnt_q   <= 16'h0000;
                        bit_q   <= 5'h00;
                        state_q <= ST_SHIFT;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_SHIFT: begin
                    if (cnt_q == 16'(SCK_HALF_CYC - 1)) begin
                        cnt_q <= 16'h0000;
                        sck_q <= ~sck_q;
                        if (!sck_q) begin
                            // sampled pin was set a half period before
                            res_sh_q <= {res_sh_q[14:0], res_sync_q[1]};
                        end else begin
                            cfg_q <= {cfg_q[6:0], 1'b0};
                            bit_q <= bit_q + 5'h01;
                            if (bit_q == 5'(FRAME_BITS - 1)) begin
                                RESULT_OUT       <= res_sh_q;
                                RESULT_VALID_OUT <= 1'b1;
                                state_q          <= ST_ACQ;
                            end
                        end
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_ACQ: begin
                    if (cnt_q == 16'(ACQ_CYCLES - 1)) begin
                        cnt_q   <= 16'h0000;
                        state_q <= ST_CST;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_CST: begin
                    if (cnt_q == 16'(CST_CYCLES - 1)) begin
                        cnt_q   <= 16'h0000;
                        state_q <= ST_WAIT_LOW;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_WAIT_LOW: begin
                    if (!busy_sync_q[1]) begin
                        state_q <= ST_WAIT_HIGH;
                    end
                end
                ST_WAIT_HIGH: begin
                    if (busy_sync_q[1]) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.shift_clk     = sck_q;
    assign link.read_n        = ~(state_q == ST_SETUP || state_q == ST_SHIFT);
    assign link.serial_cfg_in = cfg_q[7];
    assign link.convert_start = (state_q == ST_CST);
    assign READY_OUT          = (state_q == ST_IDLE) && busy_sync_q[1];
endmodule

//--- sar_link_chk.sv
// assertions on the converter control link between host and device
module sar_link_chk
    import sar_link_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    // link
    input wire logic shift_clk,
    input wire logic read_n,
    input wire logic serial_cfg_in,
    input wire logic convert_start,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sck_q;
    logic [4:0]  rise_q;
    logic [11:0] low_q;
    logic [11:0] acq_q;

    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RST_N_IN);

    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sck_q <= 1'b0;
            rise_q <= 5'h00;
        end else begin
            sck_q <= shift_clk;
            if (read_n)
                rise_q <= 5'h00;
            else if (shift_clk && !sck_q)
                rise_q <= rise_q + 5'h01;
        end
    end
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN)
            low_q <= 12'h000;
        else
            low_q <= busy ? 12'h000 : low_q + 12'h001;
    end
    // saturates so a long idle gap never wraps into a short one
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN)
            acq_q <= 12'h000;
        else if (!shift_clk && sck_q && rise_q == 5'h06)
            acq_q <= 12'h000;
        else if (acq_q != 12'hFFF)
            acq_q <= acq_q + 12'h001;
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_oe;
        serial_result_oe == !read_n;
    endproperty
    a_oe: assert property (p_oe) else $error("result pin driven outside read");
    property p_busy;
        $rose(convert_start) && busy |-> ##[2:4] !busy;
    endproperty
    a_busy: assert property (p_busy) else $error("busy did not fall after start");
    property p_conv;
        $rose(busy) |-> low_q >= CONV_CYCLES - 1 && low_q <= CONV_CYCLES + 1;
    endproperty
    a_conv: assert property (p_conv) else $error("conversion length wrong");
    property p_hold;
        $rose(convert_start) |-> convert_start [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("start pulse too short");
    property p_frame;
        $rose(read_n) |-> rise_q == 5'd16;
    endproperty
    a_frame: assert property (p_frame) else $error("frame not 16 shift clocks");
    property p_cfg_fall;
        $changed(serial_cfg_in) |-> !shift_clk;
    endproperty
    a_cfg_fall: assert property (p_cfg_fall) else $error("config bit moved on high");
    property p_sdo_fall;
        $changed(serial_result_out) && !read_n && !$past(read_n) |-> !shift_clk;
    endproperty
    a_sdo_fall: assert property (p_sdo_fall) else $error("result bit moved on high");
    property p_busy_read;
        !busy |-> read_n;
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("transfer while busy");
    property p_acq;
        $rose(convert_start) |-> acq_q >= ACQ_CYCLES;
    endproperty
    a_acq: assert property (p_acq) else $error("acquisition too short");
endmodule

//--- sar_adc_serial_conversion_control_tb.sv
// testbench: host and device joined over the link, plus a bench-driven device
module sar_adc_serial_conversion_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sar_link_pkg::*;

`define CHK(nm, ex, got) begin \
    comparisons++; \
    if ((got) !== (ex)) begin \
        num_errors++; \
        $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end \
end

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        start = 1'b0;
    logic [7:0]  cfg = 8'h00;
    logic [15:0] smp = 16'h0000;
    logic        ready;
    logic [15:0] res;
    logic        vld;
    logic [3:0]  mux;
    logic [3:0]  mux2;
    pd_mode_type pd1;
    pd_mode_type pd2;
    logic        acq1;
    logic        acq2;
    logic [15:0] sdo_w;
    logic [7:0]  cfg_w;
    logic [15:0] sdo2;
    int          nb;
    int          vcnt = 0;
    int          num_errors = 0;
    int          comparisons = 0;
    logic [7:0]  cfg_t [7] = '{8'h10, 8'h22, 8'h31, 8'h43, 8'h50, 8'hA0, 8'hF2};
    logic [15:0] smp_t [7] = '{16'h1234, 16'h0000, 16'hFFFF, 16'h7FFF,
                               16'h7FFE, 16'h8000, 16'h0001};

    always #2.5 clk = ~clk;

    sar_link_if link ();
    sar_link_if link2 ();
    sar_conv_host sar_conv_host_i (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .START_IN(start),
        .CFG_IN(cfg), .READY_OUT(ready), .RESULT_OUT(res), .RESULT_VALID_OUT(vld),
        .link(link));
    sar_conv_device sar_conv_device_i (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .SAMPLE_IN(smp),
        .MUX_ADDR_OUT(mux), .PD_MODE_OUT(pd1), .ACQUIRE_OUT(acq1), .link(link));
    // second device, short variant, whose link is driven by the bench itself
    sar_conv_device #(.RES_BITS(12)) sar_conv_device_i2 (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
        .SAMPLE_IN(16'h1234), .MUX_ADDR_OUT(mux2), .PD_MODE_OUT(pd2),
        .ACQUIRE_OUT(acq2), .link(link2));
    sar_link_chk sar_link_chk_i (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
        .shift_clk(link.shift_clk), .read_n(link.read_n),
        .serial_cfg_in(link.serial_cfg_in), .convert_start(link.convert_start),
        .serial_result_out(link.serial_result_out),
        .serial_result_oe(link.serial_result_oe), .busy(link.busy));

    // ------------------------------------------------------------
    // wire monitor and drivers
    // ------------------------------------------------------------
    always @(negedge link.read_n) nb = 0;
    always @(posedge link.shift_clk) begin
        if (link.read_n === 1'b0) begin
            sdo_w = {sdo_w[14:0], link.serial_result_out & link.serial_result_oe};
            if (nb < 8) cfg_w = {cfg_w[6:0], link.serial_cfg_in};
            nb++;
        end
    end
    always @(posedge clk) if (vld === 1'b1) vcnt++;

    task automatic conv(input logic [7:0] c, input logic [15:0] s, input logic [15:0] ex);
        pd_mode_type pd;
        pd = c[0] ? PD_SLEEP : (c[1] ? PD_NAP : PD_POWER_ON);
        for (int i = 0; i < 4000 && ready !== 1'b1; i++) @(negedge clk);
        @(posedge clk);
        start <= 1'b1;
        cfg <= c;
        smp <= s;
        // held long so that the host must refuse the repeats
        repeat (40) @(posedge clk);
        start <= 1'b0;
        for (int i = 0; i < 400 && vld !== 1'b1; i++) @(negedge clk);
        `CHK("result", ex, res)
        `CHK("wire result", ex, sdo_w)
        `CHK("wire cfg", c, cfg_w)
        `CHK("mux", c[7:4], mux)
        `CHK("pd", pd, pd1)
        `CHK("acq on", 1'b1, acq1)
        for (int i = 0; i < 4000 && link.busy !== 1'b0; i++) @(negedge clk);
        for (int i = 0; i < 4000 && link.busy !== 1'b1; i++) @(negedge clk);
        `CHK("acq off", 1'b0, acq1)
    endtask

    task automatic frame2(input logic [7:0] c, input logic rd);
        @(posedge clk);
        link2.read_n <= rd;
        repeat (4) @(posedge clk);
        // link clock of 6 ns, offset in phase from the system clock
        #1.3;
        for (int b = 0; b < 16; b++) begin
            link2.serial_cfg_in <= (b < 8) ? c[7-b] : 1'b0;
            #3;
            sdo2 = {sdo2[14:0], link2.serial_result_out & link2.serial_result_oe};
            link2.shift_clk <= 1'b1;
            #3;
            link2.shift_clk <= 1'b0;
        end
        @(negedge clk);
        `CHK("oe2", ~rd, link2.serial_result_oe)
        repeat (4) @(posedge clk);
        link2.read_n <= 1'b1;
    endtask

    task automatic pulse2;
        @(posedge clk);
        link2.convert_start <= 1'b1;
        repeat (8) @(posedge clk);
        link2.convert_start <= 1'b0;
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        link2.shift_clk = 1'b0;
        link2.read_n = 1'b1;
        link2.serial_cfg_in = 1'b0;
        link2.convert_start = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk);
        `CHK("idle busy", 1'b1, link.busy)
        `CHK("idle read", 1'b1, link.read_n)
        // result lags its request by one conversion; first word is the reset value
        for (int k = 0; k <= 7; k++) begin
            conv(cfg_t[k % 7], smp_t[k % 7], (k == 0) ? RESULT_RST : smp_t[k - 1]);
            `CHK("one valid per request", k + 1, vcnt)
            $display("test conv %0d done", k);
        end
        frame2(8'hF3, 1'b1);
        `CHK("mux2 ignored", 4'h0, mux2)
        `CHK("acq2 ignored", 1'b0, acq2)
        `CHK("wire2 off", 16'h0000, sdo2)
        frame2(8'hA2, 1'b0);
        repeat (5) @(negedge clk);
        `CHK("mux2", 4'hA, mux2)
        `CHK("pd2", PD_NAP, pd2)
        `CHK("acq2", 1'b1, acq2)
        `CHK("wire2 reset", 16'h0000, sdo2)
        pulse2();
        repeat (91) @(posedge clk);
        pulse2();
        repeat (500) @(negedge clk);
        `CHK("busy2 low", 1'b0, link2.busy)
        repeat (250) @(negedge clk);
        // a restart by the second edge would keep busy low here
        `CHK("busy2 high", 1'b1, link2.busy)
        `CHK("acq2 off", 1'b0, acq2)
        // twelve-bit result of the constant sample, low four bits padded
        frame2(8'h00, 1'b0);
        `CHK("wire2 result", 16'h1230, sdo2)
        frame2(8'h00, 1'b0);
        `CHK("wire2 held", 16'h1230, sdo2)
        $display("test ignore and restart done");
        results();
    end

    initial begin
        #200us;
        num_errors++;
        results();
    end
endmodule
